// file: bench/hfa_addr_tx_props.sv
// Checker: port-level properties of the HDLC address and tx-load block
`timescale 1ns/1ps
`default_nettype none
module hfa_addr_tx_props (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [4:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic [15:0] regRdData,
   // Receive side
   input wire logic rxByteValid,
   input wire logic rxByteFirst,
   input wire logic rxByteLast,
   input wire logic [7:0] rxByte,
   input wire logic rxFifoValid,
   input wire logic rxFifoLast,
   // Transmit side
   input wire logic txBitStrobe,
   input wire logic txBitValid,
   input wire logic txEndOfPacket,
   input wire logic txFrameAbort
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Bit slot within the byte on the wire
   logic [2:0] bitCnt_ff;
   always_ff @(posedge clock) begin
      if (!rst_n) bitCnt_ff <= 3'h0;
      else if (txBitValid) bitCnt_ff <= bitCnt_ff + 3'h1;
   end
   property p_bit_after_strobe;
      txBitValid |-> $past(txBitStrobe);
   endproperty
   a_bit_after_strobe: assert property (p_bit_after_strobe) else $error("bit without strobe");
   property p_end_last_bit;
      txEndOfPacket |-> txBitValid && bitCnt_ff == 3'h7;
   endproperty
   a_end_last_bit: assert property (p_end_last_bit) else $error("end off last bit");
   property p_abort_last_bit;
      txFrameAbort |-> txBitValid && bitCnt_ff == 3'h7;
   endproperty
   a_abort_last_bit: assert property (p_abort_last_bit) else $error("abort off last bit");
   property p_rx_from_input;
      rxFifoValid |-> $past(rxByteValid) || $past(rxByteValid, 2);
   endproperty
   a_rx_from_input: assert property (p_rx_from_input) else $error("rx byte from nowhere");
   property p_rx_last;
      rxFifoLast |-> rxFifoValid && ($past(rxByteLast) || $past(rxByteLast, 2));
   endproperty
   a_rx_last: assert property (p_rx_last) else $error("rx last misplaced");
   property p_rd_hold;
      $past(rst_n) && !$past(regRead) |-> $stable(regRdData);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_unmapped;
      regRead && regAddr == 5'h1f |=> regRdData == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   sequence s_mask_wr_rd;
      regWrite && regAddr == hfa_pkg::OFS_ADDR_MASKS ##1
         regRead && !regWrite && regAddr == hfa_pkg::OFS_ADDR_MASKS;
   endsequence
   property p_mask_back;
      s_mask_wr_rd |=> regRdData == $past(regWrData, 2);
   endproperty
   a_mask_back: assert property (p_mask_back) else $error("mask readback wrong");
   c_end: cover property (txEndOfPacket);
   c_abort: cover property (txFrameAbort);
   c_rx_last: cover property (rxFifoValid && rxFifoLast);
endmodule : hfa_addr_tx_props
bind hfa_addr_tx hfa_addr_tx_props u_props (.clock, .rst_n, .regWrite, .regRead, .regAddr,
   .regWrData, .regRdData, .rxByteValid, .rxByteFirst, .rxByteLast, .rxByte, .rxFifoValid,
   .rxFifoLast, .txBitStrobe, .txBitValid, .txEndOfPacket, .txFrameAbort);
`default_nettype wire

// file: bench/hfa_station.sv
// Remote station model: bit-slot strobes, byte capture, received byte feed
`timescale 1ns/1ps
`default_nettype none
module hfa_station (
   // Clock
   input wire logic clock,
   // Transmit serial side
   output logic txBitStrobe,
   input wire logic txBit,
   input wire logic txBitValid,
   input wire logic txEndOfPacket,
   input wire logic txFrameAbort,
   // Received byte stream
   output logic rxByteValid,
   output logic rxByteFirst,
   output logic rxByteLast,
   output logic [7:0] rxByte
);
   hfa_pkg::hfa_tx_entry_s got[$];
   logic strobeOn = 1'b0;
   logic [7:0] shiftReg = 8'h00;
   int bitPos = 0;
   int slot = 0;
   initial begin
      txBitStrobe = 1'b0;
      rxByteValid = 1'b0;
      rxByteFirst = 1'b0;
      rxByteLast = 1'b0;
      rxByte = 8'h00;
   end
   // One slot in three, like a channel share of the line
   always @(posedge clock) begin
      #1;
      slot = (slot + 1) % 3;
      txBitStrobe = strobeOn && slot == 0;
   end
   always @(posedge clock) begin
      if (txBitValid === 1'b1) begin
         shiftReg[bitPos] = txBit;
         if (bitPos == 7) got.push_back(hfa_pkg::hfa_tx_entry_s'({txFrameAbort,
            txEndOfPacket, shiftReg}));
         bitPos = (bitPos + 1) % 8;
      end
   end
   task automatic sendByte(input logic [7:0] b, input logic first, input logic last);
      rxByteValid = 1'b1;
      rxByteFirst = first;
      rxByteLast = last;
      rxByte = b;
      @(posedge clock);
      #1;
      rxByteValid = 1'b0;
      rxByteFirst = 1'b0;
      rxByteLast = 1'b0;
      // Stale byte must not look valid
      rxByte = ~b;
      @(posedge clock);
      #1;
   endtask : sendByte
endmodule : hfa_station
`default_nettype wire

// file: bench/tb.sv
// Testbench: register, address-match and transmit scenarios
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clock = 1'b0;
   logic rst_n, regWrite, regRead, rxByteValid, rxByteFirst, rxByteLast, txBitStrobe;
   logic [4:0] regAddr;
   logic [15:0] regWrData, regRdData, rdVal;
   logic [7:0] rxByte, rxFifoData;
   logic rxFifoValid, rxFifoLast, txBit, txBitValid, txEndOfPacket, txFrameAbort;
   logic [7:0] rxGot[$];
   int n_errors = 0;
   int checks_done = 0;
   always #50 clock = ~clock;
   hfa_addr_tx #(.FIFO_DEPTH(16)) DUT (.clock, .rst_n, .regWrite, .regRead, .regAddr, .regWrData,
      .regRdData, .rxByteValid, .rxByteFirst, .rxByteLast, .rxByte, .rxFifoValid, .rxFifoLast,
      .rxFifoData, .txBitStrobe, .txBit, .txBitValid, .txEndOfPacket, .txFrameAbort);
   hfa_station far (.clock, .txBitStrobe, .txBit, .txBitValid, .txEndOfPacket, .txFrameAbort,
      .rxByteValid, .rxByteFirst, .rxByteLast, .rxByte);
   always @(posedge clock) if (rxFifoValid === 1'b1) rxGot.push_back(rxFifoData);
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chkReg(input logic [15:0] got, input logic [15:0] expv);
      checks_done++;
      if (got !== expv) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, expv);
      end
   endtask : chkReg
   task automatic chkEntry(input hfa_pkg::hfa_tx_entry_s got, input logic [9:0] expv);
      chkReg({6'h00, got}, {6'h00, expv});
   endtask : chkEntry
   task automatic op(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
      regWrite = w;
      regRead = r;
      regAddr = a;
      regWrData = d;
      @(posedge clock);
      #1;
   endtask : op
   task automatic idle;
      regWrite = 1'b0;
      regRead = 1'b0;
      @(posedge clock);
      #1;
   endtask : idle
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      op(1'b1, 1'b0, a, d);
      idle();
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      op(1'b0, 1'b1, a, 16'h0000);
      idle();
      d = regRdData;
   endtask : rd
   task automatic waitTx(input int n);
      for (int i = 0; i < 2000 && far.got.size() < n; i++) begin
         @(posedge clock);
         #1;
      end
   endtask : waitTx
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic tRegs;
      rd(hfa_pkg::OFS_ADDR_MASKS, rdVal);
      chkReg(rdVal, 16'h0000);
      rd(hfa_pkg::OFS_TX_LENGTH, rdVal);
      chkReg(rdVal, 16'h0000);
      rd(hfa_pkg::OFS_STATUS, rdVal);
      chkReg(rdVal, 16'h0100);
      wr(5'h1f, 16'hffff);
      rd(5'h1f, rdVal);
      chkReg(rdVal, 16'h0000);
      op(1'b1, 1'b0, hfa_pkg::OFS_ADDR_MASKS, 16'hb5a7);
      op(1'b0, 1'b1, hfa_pkg::OFS_ADDR_MASKS, 16'h0000);
      idle();
      chkReg(regRdData, 16'hb5a7);
      wr(hfa_pkg::OFS_TX_LENGTH, 16'h00c3);
      rd(hfa_pkg::OFS_TX_LENGTH, rdVal);
      chkReg(rdVal, 16'h00c3);
   endtask : tRegs
   task automatic runCase(input logic [15:0] ctl, input logic [15:0] m, input logic [7:0] b0,
      input logic [7:0] b1, input logic two, input logic pass);
      wr(hfa_pkg::OFS_CONTROL1, ctl);
      wr(hfa_pkg::OFS_ADDR_MASKS, m);
      rxGot.delete();
      far.sendByte(b0, 1'b1, 1'b0);
      if (two) far.sendByte(b1, 1'b0, 1'b0);
      far.sendByte(8'h3c, 1'b0, 1'b1);
      repeat (3) @(posedge clock);
      #1;
      chkReg(16'(rxGot.size()), pass ? (two ? 16'h0003 : 16'h0002) : 16'h0000);
      if (pass) chkReg({8'h00, rxGot[0]}, {8'h00, b0});
   endtask : runCase
   task automatic tMatch;
      runCase(16'h0100, 16'h0055, 8'h55, 8'h00, 1'b0, 1'b1);
      runCase(16'h0100, 16'h0055, 8'h59, 8'h00, 1'b0, 1'b0);
      runCase(16'h0100, 16'h0054, 8'h59, 8'h00, 1'b0, 1'b1);
      runCase(16'h0100, 16'h0055, 8'hff, 8'h00, 1'b0, 1'b1);
      runCase(16'h0104, 16'h0057, 8'h57, 8'h00, 1'b0, 1'b1);
      runCase(16'h0104, 16'h0057, 8'h55, 8'h00, 1'b0, 1'b0);
      runCase(16'h0100, 16'h0057, 8'h55, 8'h00, 1'b0, 1'b1);
      runCase(16'h0104, 16'h0054, 8'h56, 8'h55, 1'b1, 1'b0);
      runCase(16'h0100, 16'h5555, 8'h54, 8'h55, 1'b1, 1'b1);
      runCase(16'h0100, 16'h5555, 8'h54, 8'h57, 1'b1, 1'b0);
      runCase(16'h0100, 16'h5455, 8'h54, 8'h57, 1'b1, 1'b1);
      runCase(16'h0100, 16'h5555, 8'hfc, 8'hff, 1'b1, 1'b1);
      runCase(16'h0100, 16'h5455, 8'hfc, 8'hff, 1'b1, 1'b0);
      runCase(16'h0000, 16'h0055, 8'h59, 8'h00, 1'b0, 1'b1);
   endtask : tMatch
   task automatic tTx;
      wr(hfa_pkg::OFS_CONTROL1, 16'h0000);
      wr(hfa_pkg::OFS_TX_LENGTH, 16'h0002);
      wr(hfa_pkg::OFS_TX_LOAD, 16'h00a5);
      wr(hfa_pkg::OFS_CONTROL1, 16'h00c0);
      wr(hfa_pkg::OFS_TX_LOAD, 16'h003c);
      wr(hfa_pkg::OFS_CONTROL1, 16'h0200);
      far.strobeOn = 1'b1;
      waitTx(2);
      chkReg(16'(far.got.size()), 16'h0002);
      chkEntry(far.got[0], 10'h0a5);
      chkEntry(far.got[1], 10'h33c);
      rd(hfa_pkg::OFS_STATUS, rdVal);
      chkReg({8'h00, rdVal[7:0]}, 16'h0002);
      wr(hfa_pkg::OFS_CONTROL1, 16'h0210);
      wr(hfa_pkg::OFS_TX_LENGTH, 16'h0002);
      wr(hfa_pkg::OFS_TX_LOAD, 16'h0011);
      wr(hfa_pkg::OFS_TX_LOAD, 16'h0022);
      waitTx(4);
      rd(hfa_pkg::OFS_STATUS, rdVal);
      chkReg({8'h00, rdVal[7:0]}, 16'h0000);
   endtask : tTx
   task automatic tFifo;
      far.strobeOn = 1'b0;
      wr(hfa_pkg::OFS_CONTROL1, 16'h0000);
      far.got.delete();
      op(1'b1, 1'b0, hfa_pkg::OFS_TX_LOAD, 16'h0000);
      op(1'b0, 1'b1, hfa_pkg::OFS_STATUS, 16'h0000);
      idle();
      chkReg({15'h0, regRdData[hfa_pkg::ST_EMPTY_BIT]}, 16'h0001);
      for (int i = 1; i < 17; i++) wr(hfa_pkg::OFS_TX_LOAD, 16'(i));
      rd(hfa_pkg::OFS_STATUS, rdVal);
      chkReg({14'h0, rdVal[9:8]}, 16'h0002);
      wr(hfa_pkg::OFS_CONTROL1, 16'h0200);
      far.strobeOn = 1'b1;
      waitTx(16);
      repeat (60) @(posedge clock);
      #1;
      chkReg(16'(far.got.size()), 16'h0010);
      chkEntry(far.got[15], 10'h00f);
      rd(hfa_pkg::OFS_STATUS, rdVal);
      chkReg({14'h0, rdVal[9:8]}, 16'h0001);
      wr(hfa_pkg::OFS_CONTROL1, 16'h0001);
      wr(hfa_pkg::OFS_TX_LOAD, 16'h0077);
      rd(hfa_pkg::OFS_CONTROL1, rdVal);
      chkReg(rdVal, 16'h0000);
   endtask : tFifo
   task automatic conclude;
      $display("Mismatches %0d, comparisons %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   initial begin
      #3000000;
      n_errors++;
      conclude();
   end
   initial begin
      rst_n = 1'b0;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 5'h00;
      regWrData = 16'h0000;
      repeat (20) @(posedge clock);
      #1;
      rst_n = 1'b1;
      tRegs();
      tMatch();
      tTx();
      tFifo();
      conclude();
   end
endmodule : tb
`default_nettype wire

// file: logic/hfa_addr_tx.sv
// HDLC address recognition, tx FIFO load, byte count and LSB-first serialiser
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Transmit FIFO
// ----------------------------------------------------------------
module hfa_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic flush,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_ff;
   logic [AW-1:0] rdPtr_ff;
   logic [AW:0] count_ff;
   logic doWr;
   logic doRd;

   assign inReady = (count_ff != DEPTH[AW:0]);
   assign outValid = (count_ff != '0);
   assign outData = mem[rdPtr_ff];
   assign doWr = inValid && inReady;
   assign doRd = outValid && outReady;

   // Flush clears pointers and count only; stored words are left as they were
   always_ff @(posedge clock) begin
      if (!rst_n || flush) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (doWr) wrPtr_ff <= (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
         if (doRd) rdPtr_ff <= (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
         count_ff <= count_ff + (AW+1)'(doWr) - (AW+1)'(doRd);
      end
   end

   always_ff @(posedge clock) begin
      if (doWr) mem[wrPtr_ff] <= inData;
   end
endmodule : hfa_fifo

// How it works
// - Bits 15..9 of the mask register hold the 7-bit second-address-byte mask, bit 15 its MSB.
// - An all-ones received address bypasses both masks; a two-byte one only while bit 8 is set.
// - Bit 8 enables the second-byte mask; cleared, that mask takes no part.
// - With recognition on, a packet failing the compare never reaches the receive FIFO.
// - Two-byte all-call is honoured only while the second-byte enable is set.
// - Bits 7..2 hold the 6-bit first-byte mask, bit 7 its MSB.
// - Bit 1 is an extra first-byte mask bit, used only in seven-bit address mode.
// - Bit 0 enables the first-byte mask; cleared, that mask is ignored.
// - Single-byte all-call is honoured only while the first-byte enable is set.
// - Each byte written to the tx load register while the FIFO has room and flush is clear is tagged with end and abort and queued.
// - FIFO status seen by software lags the FIFO by a settling cycle.
// - Transmit bytes are serialised least significant bit first.
// - The length register counts data bytes only; software loads it that way.
// - A counter of bytes sent from the tx FIFO is readable in the status register.
// - With cycle set the byte counter reloads from the length register each time it ends.
// - In seven-bit mode a first byte with bit 0 set is the whole address.
module hfa_addr_tx #(
   parameter int FIFO_DEPTH = hfa_pkg::TX_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Parallel register port
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [4:0] regAddr,
   input wire logic [15:0] regWrData,
   output logic [15:0] regRdData,
   // Received byte stream from the deframer
   input wire logic rxByteValid,
   input wire logic rxByteFirst,
   input wire logic rxByteLast,
   input wire logic [7:0] rxByte,
   // Toward the receive FIFO
   output logic rxFifoValid,
   output logic rxFifoLast,
   output logic [7:0] rxFifoData,
   // Transmit serial side
   input wire logic txBitStrobe,
   output logic txBit,
   output logic txBitValid,
   output logic txEndOfPacket,
   output logic txFrameAbort
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   typedef enum {RX_IDLE, RX_WAIT2, RX_EMIT2, RX_PASS, RX_DROP} hfa_rx_state_e;

   logic [15:0] masks_ff;
   logic [15:0] control_ff;
   logic [7:0] txLength_ff;
   logic [15:0] rdData_ff;
   logic wrMasks;
   logic wrControl;
   logic wrLoad;
   logic wrLength;

   assign wrMasks = regWrite && (regAddr == hfa_pkg::OFS_ADDR_MASKS);
   assign wrControl = regWrite && (regAddr == hfa_pkg::OFS_CONTROL1);
   assign wrLoad = regWrite && (regAddr == hfa_pkg::OFS_TX_LOAD);
   assign wrLength = regWrite && (regAddr == hfa_pkg::OFS_TX_LENGTH);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         masks_ff <= hfa_pkg::REG_RESET;
      end else if (wrMasks) begin
         masks_ff <= regWrData;
      end
   end

   // Reset bit self-clears on the next tx load, a later write wins
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         control_ff <= hfa_pkg::REG_RESET;
      end else if (wrControl) begin
         control_ff <= regWrData;
      end else if (wrLoad) begin
         control_ff[hfa_pkg::CTL_TX_FLUSH_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         txLength_ff <= 8'h00;
      end else if (wrLength) begin
         txLength_ff <= regWrData[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Address compare
   // ----------------------------------------------------------------
   logic seven;
   logic en1;
   logic en2;
   logic [7:0] firstHeld_ff;
   logic lastHeld_ff;
   logic matched_ff;
   hfa_rx_state_e rxState_ff;

   assign seven = control_ff[hfa_pkg::CTL_SEVEN_BIT];
   assign en1 = masks_ff[hfa_pkg::EN1_BIT];
   assign en2 = masks_ff[hfa_pkg::EN2_BIT];

   function automatic logic firstOk(input logic [7:0] b, input logic [15:0] m, input logic sv);
      logic eq;
      eq = (b[7:2] == m[hfa_pkg::MASK1_HI:hfa_pkg::MASK1_LO]);
      if (sv) eq = eq && (b[1] == m[hfa_pkg::MASK1_EXTRA_BIT]);
      return eq;
   endfunction : firstOk

   // Single-byte verdict
   function automatic logic matchOne(input logic [7:0] b, input logic [15:0] m, input logic sv);
      logic allCall;
      allCall = m[hfa_pkg::EN1_BIT] && (b[7:2] == hfa_pkg::ALL_CALL6);
      return allCall || !m[hfa_pkg::EN1_BIT] || firstOk(b, m, sv);
   endfunction : matchOne

   // Two-byte verdict
   function automatic logic matchTwo(input logic [7:0] b1, input logic [7:0] b2,
                                     input logic [15:0] m);
      logic allCall;
      logic ok2;
      allCall = m[hfa_pkg::EN2_BIT] && (b1[7:2] == hfa_pkg::ALL_CALL6)
                && (b2[7:1] == hfa_pkg::ALL_CALL7);
      ok2 = !m[hfa_pkg::EN2_BIT]
            || (b2[7:1] == m[hfa_pkg::MASK2_HI:hfa_pkg::MASK2_LO]);
      return allCall || ((!m[hfa_pkg::EN1_BIT] || firstOk(b1, m, 1'b0)) && ok2);
   endfunction : matchTwo

   logic singleAddr;
   logic recogOn;
   assign singleAddr = rxByte[0] || seven;
   assign recogOn = control_ff[hfa_pkg::CTL_RECOG_BIT];

   // Bytes are assumed to arrive with at least one idle cycle between them
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rxState_ff <= RX_IDLE;
         firstHeld_ff <= 8'h00;
         lastHeld_ff <= 1'b0;
         matched_ff <= 1'b0;
         rxFifoValid <= 1'b0;
         rxFifoLast <= 1'b0;
         rxFifoData <= 8'h00;
      end else begin
         rxFifoValid <= 1'b0;
         rxFifoLast <= 1'b0;
         case (rxState_ff)
            RX_EMIT2: begin
               rxFifoValid <= 1'b1;
               rxFifoData <= firstHeld_ff;
               rxFifoLast <= lastHeld_ff;
               rxState_ff <= lastHeld_ff ? RX_IDLE : RX_PASS;
            end
            default: begin
               if (rxByteValid && (rxByteFirst || rxState_ff == RX_IDLE)) begin
                  if (seven && !rxByte[0]) begin
                     // Seven-bit mode demands a one-byte address
                     matched_ff <= 1'b0;
                     rxState_ff <= (recogOn && !rxByteLast) ? RX_DROP : RX_IDLE;
                     if (!recogOn) begin
                        rxFifoValid <= 1'b1;
                        rxFifoData <= rxByte;
                        rxFifoLast <= rxByteLast;
                        rxState_ff <= rxByteLast ? RX_IDLE : RX_PASS;
                     end
                  end else if (singleAddr || rxByteLast) begin
                     matched_ff <= matchOne(rxByte, masks_ff, seven);
                     if (!recogOn || matchOne(rxByte, masks_ff, seven)) begin
                        rxFifoValid <= 1'b1;
                        rxFifoData <= rxByte;
                        rxFifoLast <= rxByteLast;
                        rxState_ff <= rxByteLast ? RX_IDLE : RX_PASS;
                     end else begin
                        rxState_ff <= rxByteLast ? RX_IDLE : RX_DROP;
                     end
                  end else begin
                     firstHeld_ff <= rxByte;
                     rxState_ff <= RX_WAIT2;
                  end
               end else if (rxByteValid && rxState_ff == RX_WAIT2) begin
                  matched_ff <= matchTwo(firstHeld_ff, rxByte, masks_ff);
                  if (!recogOn || matchTwo(firstHeld_ff, rxByte, masks_ff)) begin
                     rxFifoValid <= 1'b1;
                     rxFifoData <= firstHeld_ff;
                     firstHeld_ff <= rxByte;
                     lastHeld_ff <= rxByteLast;
                     rxState_ff <= RX_EMIT2;
                  end else begin
                     rxState_ff <= rxByteLast ? RX_IDLE : RX_DROP;
                  end
               end else if (rxByteValid && rxState_ff == RX_PASS) begin
                  rxFifoValid <= 1'b1;
                  rxFifoData <= rxByte;
                  rxFifoLast <= rxByteLast;
                  if (rxByteLast) rxState_ff <= RX_IDLE;
               end else if (rxByteValid && rxState_ff == RX_DROP && rxByteLast) begin
                  rxState_ff <= RX_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Transmit FIFO load and drain
   // ----------------------------------------------------------------
   hfa_pkg::hfa_tx_entry_s loadEntry;
   hfa_pkg::hfa_tx_entry_s headEntry;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoPop;

   assign loadEntry.frameAbort = control_ff[hfa_pkg::CTL_ABORT_BIT];
   assign loadEntry.endOfPacket = control_ff[hfa_pkg::CTL_END_BIT];
   assign loadEntry.data = regWrData[7:0];

   hfa_fifo #(
      .WIDTH($bits(hfa_pkg::hfa_tx_entry_s)),
      .DEPTH(FIFO_DEPTH)
   ) txFifo (
      .clock(clock),
      .rst_n(rst_n),
      .flush(control_ff[hfa_pkg::CTL_TX_FLUSH_BIT]),
      .inValid(wrLoad),
      .inReady(fifoInReady),
      .inData(loadEntry),
      .outValid(fifoOutValid),
      .outReady(fifoPop),
      .outData(headEntry)
   );

   // Status lags the FIFO so software never sees a half-moved word
   logic stEmpty_ff;
   logic stFull_ff;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stEmpty_ff <= 1'b1;
         stFull_ff <= 1'b0;
      end else begin
         stEmpty_ff <= !fifoOutValid;
         stFull_ff <= !fifoInReady;
      end
   end

   // ----------------------------------------------------------------
   // Serialiser and byte counter
   // ----------------------------------------------------------------
   logic [7:0] shift_ff;
   logic [3:0] bitsLeft_ff;
   logic endHeld_ff;
   logic abortHeld_ff;
   logic [7:0] remaining_ff;
   logic txEnable;

   assign txEnable = control_ff[hfa_pkg::CTL_TX_ON_BIT];
   assign fifoPop = txEnable && txBitStrobe && (bitsLeft_ff == 4'h0) && fifoOutValid;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         shift_ff <= 8'h00;
         bitsLeft_ff <= 4'h0;
         endHeld_ff <= 1'b0;
         abortHeld_ff <= 1'b0;
         txBit <= 1'b0;
         txBitValid <= 1'b0;
         txEndOfPacket <= 1'b0;
         txFrameAbort <= 1'b0;
      end else begin
         txBitValid <= 1'b0;
         txEndOfPacket <= 1'b0;
         txFrameAbort <= 1'b0;
         if (fifoPop) begin
            txBit <= headEntry.data[0];
            txBitValid <= 1'b1;
            shift_ff <= {1'b0, headEntry.data[7:1]};
            bitsLeft_ff <= 4'(hfa_pkg::BITS_PER_BYTE - 1);
            endHeld_ff <= headEntry.endOfPacket;
            abortHeld_ff <= headEntry.frameAbort;
         end else if (txBitStrobe && bitsLeft_ff != 4'h0) begin
            txBit <= shift_ff[0];
            txBitValid <= 1'b1;
            shift_ff <= {1'b0, shift_ff[7:1]};
            bitsLeft_ff <= bitsLeft_ff - 4'h1;
            if (bitsLeft_ff == 4'h1) begin
               txEndOfPacket <= endHeld_ff;
               txFrameAbort <= abortHeld_ff;
            end
         end
      end
   end

   // Counts down per byte popped; sent count is length minus what is left
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         remaining_ff <= 8'h00;
      end else if (wrLength) begin
         remaining_ff <= regWrData[7:0];
      end else if (fifoPop) begin
         if (remaining_ff == 8'h01 && control_ff[hfa_pkg::CTL_CYCLE_BIT]) begin
            remaining_ff <= txLength_ff;
         end else if (remaining_ff != 8'h00) begin
            remaining_ff <= remaining_ff - 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [15:0] statusWord;
   always_comb begin
      statusWord = 16'h0000;
      statusWord[7:0] = txLength_ff - remaining_ff;
      statusWord[hfa_pkg::ST_EMPTY_BIT] = stEmpty_ff;
      statusWord[hfa_pkg::ST_FULL_BIT] = stFull_ff;
      statusWord[hfa_pkg::ST_MATCH_BIT] = matched_ff;
   end

   // Load register is write-only and reads as zero
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdData_ff <= 16'h0000;
      end else if (regRead) begin
         if (regAddr == hfa_pkg::OFS_ADDR_MASKS) begin
            rdData_ff <= masks_ff;
         end else if (regAddr == hfa_pkg::OFS_CONTROL1) begin
            rdData_ff <= control_ff;
         end else if (regAddr == hfa_pkg::OFS_TX_LENGTH) begin
            rdData_ff <= {8'h00, txLength_ff};
         end else if (regAddr == hfa_pkg::OFS_STATUS) begin
            rdData_ff <= statusWord;
         end else begin
            rdData_ff <= 16'h0000;
         end
      end
   end

   assign regRdData = rdData_ff;
endmodule : hfa_addr_tx

`default_nettype wire

// file: logic/hfa_pkg.sv
// Package: register map, field layout and carrier types of the HDLC address/tx-load block
package hfa_pkg;
   // ----------------------------------------------------------------
   // Register offsets on the parallel register port
   // ----------------------------------------------------------------
   localparam logic [4:0] OFS_CONTROL1 = 5'h02;
   localparam logic [4:0] OFS_ADDR_MASKS = 5'h04;
   localparam logic [4:0] OFS_TX_LOAD = 5'h05;
   localparam logic [4:0] OFS_TX_LENGTH = 5'h06;
   localparam logic [4:0] OFS_STATUS = 5'h1c;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int MASK2_HI = 15;
   localparam int MASK2_LO = 9;
   localparam int EN2_BIT = 8;
   localparam int MASK1_HI = 7;
   localparam int MASK1_LO = 2;
   localparam int MASK1_EXTRA_BIT = 1;
   localparam int EN1_BIT = 0;

   localparam int CTL_TX_FLUSH_BIT = 0;
   localparam int CTL_SEVEN_BIT = 2;
   localparam int CTL_CYCLE_BIT = 4;
   localparam int CTL_END_BIT = 6;
   localparam int CTL_ABORT_BIT = 7;
   localparam int CTL_RECOG_BIT = 8;
   localparam int CTL_TX_ON_BIT = 9;

   localparam int ST_EMPTY_BIT = 8;
   localparam int ST_FULL_BIT = 9;
   localparam int ST_MATCH_BIT = 10;

   // ----------------------------------------------------------------
   // Reset values, all-call patterns and sizes
   // ----------------------------------------------------------------
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [5:0] ALL_CALL6 = 6'h3f;
   localparam logic [6:0] ALL_CALL7 = 7'h7f;
   localparam int TX_FIFO_DEPTH = 16;
   localparam int BITS_PER_BYTE = 8;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic frameAbort;
      logic endOfPacket;
      logic [7:0] data;
   } hfa_tx_entry_s;

   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] data;
   } hfa_rx_byte_s;
endpackage : hfa_pkg
